// *** verilog/sps_regs.svh ***
// Register offsets, field positions, reset values and link frame constants
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ==========================================================
// Register map
`define SPS_OFS_PATH 5'h0_0
`define SPS_OFS_STATUS 5'h1_A
`define SPS_PATH_RESET 8'h0_0
`define SPS_STATUS_RESET 8'h0_0
`define SPS_ZERO_BYTE 8'h0_0

// ==========================================================
// Status bit positions
`define SPS_ST_CMD_PERR 6
`define SPS_ST_DATA_PERR 3
`define SPS_ST_RD_UNUSED 2
`define SPS_ST_WR_UNUSED 1

// ==========================================================
// Path-select codes, one per throw
`define SPS_SEL_T1 3'h6
`define SPS_SEL_T2 3'h4
`define SPS_SEL_T3 3'h2
`define SPS_SEL_T4 3'h0
`define SPS_SEL_T5 3'h7
`define SPS_SEL_T6 3'h5
`define SPS_SEL_T7 3'h3
`define SPS_SEL_T8 3'h1

// ==========================================================
// Link frame layout
`define SPS_CMD_BITS 4'h0_00D
`define SPS_DATA_BITS 4'h0_009
`define SPS_CNT_ZERO 4'h0_000
`define SPS_CNT_ONE 4'h0_001
`define SPS_OP_WRITE 3'h2
`define SPS_OP_READ 3'h3
`define SPS_TARGET_ID 4'h0_005

`endif

// *** verilog/sps_pkg.sv ***
// Types shared by the path-select switch controller
package sps_pkg;

   // ==========================================================
   // Link receiver states
   typedef enum logic [2:0] {
      SPS_IDLE = 3'b000,
      SPS_CMD = 3'b001,
      SPS_WDATA = 3'b010,
      SPS_PARK = 3'b011,
      SPS_RPARK = 3'b100,
      SPS_RDOUT = 3'b101,
      SPS_REND = 3'b110
   } sps_state_t;

   // ==========================================================
   // Event kinds passed from the link to the register side
   typedef enum logic [1:0] {
      SPS_EV_WRITE = 2'b00,
      SPS_EV_CMD_PERR = 2'b01,
      SPS_EV_DATA_PERR = 2'b10,
      SPS_EV_RD_UNUSED = 2'b11
   } sps_ev_t;

   typedef struct packed {
      sps_ev_t kind;
      logic [4:0] addr;
      logic [7:0] data;
   } sps_msg_t;

endpackage

// *** verilog/sps_tgl_sync.sv ***
// Toggle synchroniser turning a far-domain toggle into a one-cycle pulse
`timescale 1ns/1ns
module sps_tgl_sync (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic tgl_in,
   output logic pulse
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // ==========================================================
   // Two stages, then edge detect on the settled stage only
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= tgl_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign pulse = sync_q ^ last_q;

endmodule

// *** verilog/sps_switch_ctrl.sv ***
// Path-select switch controller: two-wire link slave and throw decode
`timescale 1ns/1ns
`include "sps_regs.svh"
module sps_switch_ctrl (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sdata_in,
   output logic sdata_out,
   output logic sdata_oe_b,
   output logic [7:0] rf_throw_en,
   output logic [7:0] path_select
);
   import sps_pkg::*;

   // ==========================================================
   // Link domain declarations
   logic ssc_tgl_q;
   logic ssc_last_q;
   logic start;
   sps_state_t state_q;
   logic [3:0] cnt_q;
   logic [12:0] sh_q;
   logic [4:0] addr_q;
   sps_msg_t msg_q;
   logic msg_tgl_q;
   logic [15:0] rb_meta_q;
   logic [15:0] rb_q;
   logic [8:0] out_sh_q;
   logic [7:0] rd_byte;
   logic [12:0] cmd_word;
   logic [8:0] data_word;

   // Register side declarations
   logic [7:0] path_q;
   logic [7:0] status_q;
   logic [7:0] throw_q;
   logic msg_pulse;

   // ==========================================================
   // Start condition: data falling while the clock is low never happens
   // inside a frame, so it is caught on the data edge itself. The reset
   // here is asynchronous, since the link clock may be still during reset.
   always_ff @(negedge sdata_in or negedge rst_b) begin
      if (!rst_b) begin
         ssc_tgl_q <= 1'b0;
      end else if (!sclk) begin
         ssc_tgl_q <= ~ssc_tgl_q;
      end
   end

   assign start = ssc_tgl_q ^ ssc_last_q;
   assign cmd_word = {sh_q[11:0], sdata_in};
   assign data_word = {sh_q[7:0], sdata_in};

   // ==========================================================
   // Frame receiver, sampling on the falling link clock edge
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         ssc_last_q <= 1'b0;
         state_q <= SPS_IDLE;
         cnt_q <= `SPS_CNT_ZERO;
         sh_q <= 13'h0_000;
         addr_q <= 5'h0_0;
         msg_q <= '0;
         msg_tgl_q <= 1'b0;
      end else if (start) begin
         ssc_last_q <= ssc_tgl_q;
         state_q <= SPS_CMD;
         cnt_q <= `SPS_CNT_ONE;
         sh_q <= {12'h0_000, sdata_in};
      end else begin
         sh_q <= {sh_q[11:0], sdata_in};
         cnt_q <= cnt_q + `SPS_CNT_ONE;
         unique case (state_q)
            SPS_IDLE: begin
               cnt_q <= `SPS_CNT_ZERO;
            end
            SPS_CMD: begin
               if (cnt_q == `SPS_CMD_BITS - `SPS_CNT_ONE) begin
                  state_q <= SPS_IDLE;
                  cnt_q <= `SPS_CNT_ZERO;
                  if (cmd_word[12:9] == `SPS_TARGET_ID) begin
                     if (!(^cmd_word)) begin
                        msg_q <= '{SPS_EV_CMD_PERR, 5'h0_0, 8'h0_0};
                        msg_tgl_q <= ~msg_tgl_q;
                     end else if (cmd_word[8]) begin
                        // Compact write of seven bits to path-select
                        msg_q <= '{SPS_EV_WRITE, `SPS_OFS_PATH,
                                   {1'b0, cmd_word[7:1]}};
                        msg_tgl_q <= ~msg_tgl_q;
                        state_q <= SPS_PARK;
                     end else if (cmd_word[8:6] == `SPS_OP_WRITE) begin
                        addr_q <= cmd_word[5:1];
                        state_q <= SPS_WDATA;
                     end else if (cmd_word[8:6] == `SPS_OP_READ) begin
                        addr_q <= cmd_word[5:1];
                        state_q <= SPS_RPARK;
                        if (cmd_word[5:1] != `SPS_OFS_PATH &&
                            cmd_word[5:1] != `SPS_OFS_STATUS) begin
                           msg_q <= '{SPS_EV_RD_UNUSED, cmd_word[5:1],
                                      8'h0_0};
                           msg_tgl_q <= ~msg_tgl_q;
                        end
                     end
                  end
               end
            end
            SPS_WDATA: begin
               if (cnt_q == `SPS_DATA_BITS - `SPS_CNT_ONE) begin
                  cnt_q <= `SPS_CNT_ZERO;
                  state_q <= SPS_PARK;
                  if (^data_word) begin
                     msg_q <= '{SPS_EV_WRITE, addr_q,
                                data_word[8:1]};
                  end else begin
                     msg_q <= '{SPS_EV_DATA_PERR, addr_q, 8'h0_0};
                  end
                  msg_tgl_q <= ~msg_tgl_q;
               end
            end
            SPS_PARK: begin
               state_q <= SPS_IDLE;
            end
            SPS_RPARK: begin
               state_q <= SPS_RDOUT;
               cnt_q <= `SPS_CNT_ZERO;
            end
            SPS_RDOUT: begin
               if (cnt_q == `SPS_DATA_BITS - `SPS_CNT_ONE) begin
                  state_q <= SPS_REND;
               end
            end
            SPS_REND: begin
               state_q <= SPS_IDLE;
            end
            default: begin
               state_q <= SPS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Read-back values change only on writes and error events, long before they are read,
   // so a two-stage copy on the link clock is enough for them
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         rb_meta_q <= 16'h0_000;
         rb_q <= 16'h0_000;
      end else begin
         rb_meta_q <= {status_q, path_q};
         rb_q <= rb_meta_q;
      end
   end

   assign rd_byte = (addr_q == `SPS_OFS_PATH) ? rb_q[7:0] :
                    (addr_q == `SPS_OFS_STATUS) ? rb_q[15:8] :
                    `SPS_ZERO_BYTE;

   // ==========================================================
   // Read answer, driven on the rising link clock edge with odd parity
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         out_sh_q <= 9'h0_00;
         sdata_out <= 1'b0;
         sdata_oe_b <= 1'b1;
      end else begin
         unique case (state_q)
            SPS_RPARK: begin
               out_sh_q <= {rd_byte, ~(^rd_byte)};
               sdata_oe_b <= 1'b1;
            end
            SPS_RDOUT: begin
               sdata_out <= out_sh_q[8];
               out_sh_q <= {out_sh_q[7:0], 1'b0};
               sdata_oe_b <= 1'b0;
            end
            SPS_REND: begin
               // Drive the park low for one cycle, then let go
               sdata_out <= 1'b0;
               sdata_oe_b <= 1'b0;
            end
            default: begin
               sdata_out <= 1'b0;
               sdata_oe_b <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Crossing: the message stays still for a whole frame after its toggle
   sps_tgl_sync u_msg_sync (
      .clk(clk),
      .rst_b(rst_b),
      .tgl_in(msg_tgl_q),
      .pulse(msg_pulse)
   );

   // ==========================================================
   // Path-select register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         path_q <= `SPS_PATH_RESET;
      end else if (msg_pulse && msg_q.kind == SPS_EV_WRITE &&
                   msg_q.addr == `SPS_OFS_PATH) begin
         path_q <= msg_q.data;
      end
   end

   // Status flags: events set, a write of one clears, one message per pulse so the two never meet
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_q <= `SPS_STATUS_RESET;
      end else if (msg_pulse) begin
         unique case (msg_q.kind)
            SPS_EV_WRITE: begin
               if (msg_q.addr == `SPS_OFS_STATUS) begin
                  status_q <= status_q & ~msg_q.data;
               end else if (msg_q.addr != `SPS_OFS_PATH) begin
                  status_q[`SPS_ST_WR_UNUSED] <= 1'b1;
               end
            end
            SPS_EV_CMD_PERR: status_q[`SPS_ST_CMD_PERR] <= 1'b1;
            SPS_EV_DATA_PERR: status_q[`SPS_ST_DATA_PERR] <= 1'b1;
            SPS_EV_RD_UNUSED: status_q[`SPS_ST_RD_UNUSED] <= 1'b1;
         endcase
      end
   end

   // ==========================================================
   // Throw decode, one-hot, bit n is throw n+1
   function automatic logic [7:0] sps_decode(input logic [2:0] sel);
      logic [7:0] onehot;
      onehot = 8'h0_0;
      unique case (sel)
         `SPS_SEL_T1: onehot[0] = 1'b1;
         `SPS_SEL_T2: onehot[1] = 1'b1;
         `SPS_SEL_T3: onehot[2] = 1'b1;
         `SPS_SEL_T4: onehot[3] = 1'b1;
         `SPS_SEL_T5: onehot[4] = 1'b1;
         `SPS_SEL_T6: onehot[5] = 1'b1;
         `SPS_SEL_T7: onehot[6] = 1'b1;
         `SPS_SEL_T8: onehot[7] = 1'b1;
      endcase
      return onehot;
   endfunction

   // Registered so the switch drivers never see a decode glitch
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         throw_q <= sps_decode(3'(`SPS_PATH_RESET));
      end else begin
         throw_q <= sps_decode(path_q[2:0]);
      end
   end

   assign rf_throw_en = throw_q;
   assign path_select = path_q;

endmodule

// *** verification/sps_switch_chk.sv ***
// Concurrent checks on the path-select switch controller ports
`timescale 1ns/1ns
module sps_switch_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic sdata_in,
   input wire logic sdata_out,
   input wire logic sdata_oe_b,
   input wire logic [7:0] rf_throw_en,
   input wire logic [7:0] path_select
);
   // Throw enable for each code, code n in byte n
   localparam logic [63:0] THR = 64'h1001_2002_4004_8008;
   // ==========================================================
   // Throw decode, one clk behind the register
   chk_map_first: assert property (@(posedge clk) disable iff (!rst_b)
      $past(path_select[2:0]) inside {3'h6, 3'h4, 3'h2}
      |-> rf_throw_en == THR[8*$past(path_select[2:0]) +: 8])
      else $error("wrong throw for codes 6 4 2");
   chk_map_mid: assert property (@(posedge clk) disable iff (!rst_b)
      $past(path_select[2:0]) inside {3'h0, 3'h7, 3'h5}
      |-> rf_throw_en == THR[8*$past(path_select[2:0]) +: 8])
      else $error("wrong throw for codes 0 7 5");
   chk_map_last: assert property (@(posedge clk) disable iff (!rst_b)
      $past(path_select[2:0]) inside {3'h3, 3'h1}
      |-> rf_throw_en == THR[8*$past(path_select[2:0]) +: 8])
      else $error("wrong throw for codes 3 1");
   chk_one_hot: assert property (@(posedge clk) disable iff (!rst_b)
      $onehot(rf_throw_en))
      else $error("throw enables not one-hot");
   // Upper register bits must never steer the switch
   chk_upper_ignored: assert property (@(posedge clk) disable iff (!rst_b)
      $stable(path_select[2:0]) |=> $stable(rf_throw_en))
      else $error("throw moved without a code change");
   // ==========================================================
   // Read answers
   chk_read_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !sdata_oe_b |-> $stable(path_select))
      else $error("register changed during a read");
   chk_oe_bits: assert property (@(posedge sclk) disable iff (!rst_b)
      $fell(sdata_oe_b) |-> !sdata_oe_b [*8])
      else $error("data pin released inside the byte");
   chk_oe_release: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(sdata_oe_b) |-> ##[1:8] sdata_oe_b)
      else $error("data pin not released after the read");
   cover property (@(posedge clk) path_select[2:0] == 3'h1);
   cover property (@(posedge clk) $fell(sdata_oe_b));
   cover property (@(posedge clk) path_select[7]);
endmodule

bind sps_switch_ctrl sps_switch_chk i_sps_switch_chk (.clk(clk),
   .rst_b(rst_b), .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out),
   .sdata_oe_b(sdata_oe_b), .rf_throw_en(rf_throw_en),
   .path_select(path_select));

// *** verification/sps_master.sv ***
// Bus master model driving the link clock and data wire
`timescale 1ns/1ns
module sps_master (
   output logic sclk,
   output logic sdata_in,
   input wire logic sdata_out,
   input wire logic sdata_oe_b
);
   logic m_d;
   logic m_en;
   // Wire level: master, else device, else the pull-down
   assign sdata_in = m_en ? m_d : (!sdata_oe_b ? sdata_out : 1'b0);
   initial begin
      sclk = 1'b0;
      m_d = 1'b0;
      m_en = 1'b0;
   end
   // ==========================================================
   // One 12 ns bit: data moves on the rise, device samples the fall
   task automatic bit_out(input logic b);
      sclk = 1'b1;
      m_d = b;
      #6;
      sclk = 1'b0;
      #6;
   endtask
   // kind 0 register-0 write, 1 write, 2 read; bad 1/2 spoils a parity
   task automatic xfer(input logic [3:0] id, input logic [7:0] cmd,
      input logic [7:0] d, input int kind, input int bad,
      output logic [8:0] rd);
      logic [12:0] f;
      logic [8:0] df;
      f = {id, cmd, ~^{id, cmd} ^ (bad == 1)};
      df = {d, ~^d ^ (bad == 2)};
      rd = '0;
      m_en = 1'b1;
      // Start: data pulse while the clock stands low
      m_d = 1'b1;
      #6;
      m_d = 1'b0;
      #6;
      for (int i = 12; i >= 0; i--) bit_out(f[i]);
      if (kind == 1) begin
         for (int i = 8; i >= 0; i--) bit_out(df[i]);
      end
      bit_out(1'b0);
      m_en = 1'b0;
      // Read: device drives on the rise, taken on the fall
      if (kind == 2) begin
         for (int i = 10; i >= 0; i--) begin
            sclk = 1'b1;
            #6;
            sclk = 1'b0;
            if (i > 1) rd[i-2] = sdata_in;
            #6;
         end
      end
   endtask
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the path-select switch controller
`timescale 1ns/1ns
module testbench;
   localparam logic [63:0] THR = 64'h1001_2002_4004_8008;
   logic clk;
   logic rst_b;
   logic sclk;
   logic sdata_in;
   logic sdata_out;
   logic sdata_oe_b;
   logic [7:0] rf_throw_en;
   logic [7:0] path_select;
   logic [8:0] rd;
   logic [7:0] v;
   int failures;
   int tests_run;
   int seed;
   int reg0_m;
   sps_switch_ctrl i_sps_switch_ctrl (.clk(clk), .rst_b(rst_b),
      .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out),
      .sdata_oe_b(sdata_oe_b), .rf_throw_en(rf_throw_en),
      .path_select(path_select));
   sps_master i_sps_master (.sclk(sclk), .sdata_in(sdata_in),
      .sdata_out(sdata_out), .sdata_oe_b(sdata_oe_b));
   // ==========================================================
   // Clock and watchdog, the run needs well under 1000 cycles
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      test_done;
   end
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // One transfer, then 8 clk for the crossing before comparing
   task automatic run(input logic [3:0] id, input logic [7:0] cmd,
      input logic [7:0] d, input int kind, input int bad);
      i_sps_master.xfer(id, cmd, d, kind, bad, rd);
      repeat (8) @(posedge clk);
      check8(path_select, reg0_m[7:0]);
      check8(rf_throw_en, THR[8*reg0_m[2:0] +: 8]);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'h53e0;
      rst_b = 1'b0;
      failures = 0;
      tests_run = 0;
      reg0_m = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      // Reset leaves code 0 in place, so throw 4 alone is on
      check8(path_select, 8'h00);
      check8(rf_throw_en, THR[7:0]);
      // Every code, random upper bits, via the compact write
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, 4'($random(seed)), 3'(c)};
         reg0_m = v;
         run(4'h5, {1'b1, v[6:0]}, 8'h00, 0, 0);
      end
      v = 8'($random(seed));
      reg0_m = v;
      run(4'h5, 8'h40, v, 1, 0);
      run(4'h5, 8'h60, 8'h00, 2, 0);
      check8(rd[8:1], v);
      check8({7'h00, rd[0]}, {7'h00, ~^v});
      // Refused frames leave the switch where it was
      run(4'h3, 8'h81, 8'h00, 0, 0);
      run(4'h5, 8'h83, 8'h00, 0, 1);
      run(4'h5, 8'h40, 8'h11, 1, 2);
      run(4'h5, 8'h65, 8'h00, 2, 0);
      check8(rd[8:1], 8'h00);
      // Status gathers both parity faults and the unused read
      run(4'h5, 8'h7A, 8'h00, 2, 0);
      check8(rd[8:1], 8'h4C);
      // Write to an unused address flags it, switch stays put
      run(4'h5, 8'h43, 8'h5A, 1, 0);
      run(4'h5, 8'h7A, 8'h00, 2, 0);
      check8(rd[8:1], 8'h4E);
      // Writing ones clears only the flags named in the byte
      run(4'h5, 8'h5A, 8'h48, 1, 0);
      run(4'h5, 8'h7A, 8'h00, 2, 0);
      check8(rd[8:1], 8'h06);
      // Reset in mid-run returns to throw 4 and clears every flag
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      reg0_m = 0;
      run(4'h5, 8'h7A, 8'h00, 2, 0);
      check8(rd[8:1], 8'h00);
      test_done;
   end
endmodule
